// [hdl/rbg_consts.svh]
`ifndef RBG_CONSTS_SVH
`define RBG_CONSTS_SVH

// Register byte offsets
`define RBG_OFS_SEND_SEL   12'h604
`define RBG_OFS_SRC_IP     12'h608
`define RBG_OFS_CTRL       12'h610
`define RBG_OFS_PERIOD     12'h614
`define RBG_OFS_TIMEOUT    12'h618
`define RBG_OFS_WINDOW     12'h61C
`define RBG_OFS_PORT_SET   12'h628
`define RBG_OFS_STATUS     12'h630

// Field positions
`define RBG_BIT_UNICAST    31
`define RBG_BIT_ASSIST     0
`define RBG_BIT_TX_ON      1
`define RBG_BIT_BACKUP     2
`define RBG_BIT_SEQ_CLR    3

// Send method codes
`define RBG_METHOD_ONE     2'h0
`define RBG_METHOD_PAIR    2'h1

// Reset values
`define RBG_RST_PERIOD     32'd400
`define RBG_RST_TIMEOUT    22'd1960
`define RBG_RST_WINDOW     22'd6000

// Timing: microsecond tick from the core clock
`define RBG_CLK_NS         20
`define RBG_US_NS          1000
`define RBG_US_CYCLES      (`RBG_US_NS / `RBG_CLK_NS)

`endif

// [hdl/rbg_pkg.sv]
package rbg_pkg;

    // Backup-supervisor takeover states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARMED,
        ST_WAIT2,
        ST_HOLD,
        ST_AUTO
    } rbg_state_e;

    typedef logic [31:0] rbg_word_t;
    typedef logic [21:0] rbg_us22_t;
    typedef logic [6:0]  rbg_ports_t;

endpackage : rbg_pkg

// [hdl/rbg_us_tick.sv]
`timescale 1ns/100ps
`include "rbg_consts.svh"

module rbg_us_tick (
    input  wire logic clk_sys,
    input  wire logic reset,
    output logic      tick
);

    localparam logic [5:0] LAST = 6'(`RBG_US_CYCLES - 1);

    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;
    logic       tick_reg;
    logic       tick_next;

    // One-cycle pulse every microsecond
    always_comb begin
        tick_next = (cnt_reg == LAST);
        cnt_next  = tick_next ? 6'h00 : cnt_reg + 6'h01;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_reg  <= 6'h00;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule : rbg_us_tick

// [hdl/rbg_top.sv]
`timescale 1ns/100ps
`include "rbg_consts.svh"
module rbg_top (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [11:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        loss_port1,
    input  wire logic        loss_port2,
    output logic             beacon_send,
    output logic      [6:0]  beacon_ports,
    output logic             beacon_unicast,
    output logic      [15:0] beacon_seq_id,
    output logic      [31:0] beacon_ip_field,
    output logic      [31:0] beacon_interval_field,
    output logic      [21:0] beacon_timeout_field,
    output logic             ring_hw_assist_on,
    output logic             supervisor_active
);

    // Merge write data under byte enables
    function automatic logic [31:0] rbg_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction : rbg_merge

    // Lowest set port of a map, one-hot
    function automatic rbg_pkg::rbg_ports_t rbg_first(input rbg_pkg::rbg_ports_t m);
        rbg_pkg::rbg_ports_t res;
        res = 7'h00;
        for (int i = 6; i >= 0; i--) begin
            if (m[i]) begin
                res = 7'h00;
                res[i] = 1'b1;
            end
        end
        return res;
    endfunction : rbg_first

    logic                 us_tick;
    logic                 wait_reg,   wait_next;
    logic [31:0]          rdata_reg,  rdata_next;
    logic                 uni_reg,    uni_next;
    logic [1:0]           method_reg, method_next;
    rbg_pkg::rbg_word_t   ip_reg,     ip_next;
    logic [3:0]           ctrl_reg,   ctrl_next;
    rbg_pkg::rbg_word_t   period_reg, period_next;
    rbg_pkg::rbg_us22_t   tmo_reg,    tmo_next;
    rbg_pkg::rbg_us22_t   win_reg,    win_next;
    rbg_pkg::rbg_ports_t  pset_reg,   pset_next;
    logic [31:0]          w;

    // Engine state is declared ahead of the bus decoder, which reads it
    rbg_pkg::rbg_state_e st_reg, st_next;
    logic                bk_prev_reg, tx_prev_reg;
    logic [1:0]          seen_reg,  seen_next;
    rbg_pkg::rbg_us22_t  wcnt_reg,  wcnt_next;
    rbg_pkg::rbg_word_t  icnt_reg,  icnt_next;
    logic [15:0]         seq_reg,   seq_next;
    logic                pend_reg,  pend_next;
    logic                send_reg,  send_next;
    logic                uniout_reg, uniout_next;
    rbg_pkg::rbg_ports_t ports_reg, ports_next;
    logic                act_reg;
    logic                assist, tx_on, backup, active, fire;
    logic [1:0]          loss;
    rbg_pkg::rbg_ports_t p1, p2;

    rbg_us_tick u_tick (
        .clk_sys (clk_sys),
        .reset   (reset),
        .tick    (us_tick)
    );

    // Bus slave: waitrequest high until one answer cycle
    always_comb begin
        wait_next   = !(wait_reg && (avs_read || avs_write));
        rdata_next  = rdata_reg;
        uni_next    = uni_reg;
        method_next = method_reg;
        ip_next     = ip_reg;
        ctrl_next   = ctrl_reg;
        period_next = period_reg;
        tmo_next    = tmo_reg;
        win_next    = win_reg;
        pset_next   = pset_reg;
        w           = 32'h00000000;
        if (avs_read && wait_reg) begin
            if (avs_address == `RBG_OFS_SEND_SEL) begin
                rdata_next = {uni_reg, 29'h00000000, method_reg};
            end else if (avs_address == `RBG_OFS_SRC_IP) begin
                rdata_next = ip_reg;
            end else if (avs_address == `RBG_OFS_CTRL) begin
                rdata_next = {28'h0000000, ctrl_reg};
            end else if (avs_address == `RBG_OFS_PERIOD) begin
                rdata_next = period_reg;
            end else if (avs_address == `RBG_OFS_TIMEOUT) begin
                rdata_next = {10'h000, tmo_reg};
            end else if (avs_address == `RBG_OFS_WINDOW) begin
                rdata_next = {10'h000, win_reg};
            end else if (avs_address == `RBG_OFS_PORT_SET) begin
                rdata_next = {25'h0000000, pset_reg};
            end else if (avs_address == `RBG_OFS_STATUS) begin
                rdata_next = {seq_reg, 11'h000, active, 1'b0, 3'(st_reg)};
            end else begin
                rdata_next = 32'h00000000; // Unmapped reads zero
            end
        end
        // Write lands on the edge that sees waitrequest low
        if (avs_write && !wait_reg) begin
            if (avs_address == `RBG_OFS_SEND_SEL) begin
                w           = rbg_merge({uni_reg, 29'h00000000, method_reg},
                                        avs_writedata, avs_byteenable);
                uni_next    = w[`RBG_BIT_UNICAST];
                method_next = w[1:0];
            end else if (avs_address == `RBG_OFS_SRC_IP) begin
                ip_next     = rbg_merge(ip_reg, avs_writedata, avs_byteenable);
            end else if (avs_address == `RBG_OFS_CTRL) begin
                w           = rbg_merge({28'h0000000, ctrl_reg}, avs_writedata,
                                        avs_byteenable);
                ctrl_next   = w[3:0];
            end else if (avs_address == `RBG_OFS_PERIOD) begin
                period_next = rbg_merge(period_reg, avs_writedata, avs_byteenable);
            end else if (avs_address == `RBG_OFS_TIMEOUT) begin
                w           = rbg_merge({10'h000, tmo_reg}, avs_writedata,
                                        avs_byteenable);
                tmo_next    = w[21:0];
            end else if (avs_address == `RBG_OFS_WINDOW) begin
                w           = rbg_merge({10'h000, win_reg}, avs_writedata,
                                        avs_byteenable);
                win_next    = w[21:0];
            end else if (avs_address == `RBG_OFS_PORT_SET) begin
                w           = rbg_merge({25'h0000000, pset_reg}, avs_writedata,
                                        avs_byteenable);
                pset_next   = w[6:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wait_reg   <= 1'b1;
            rdata_reg  <= 32'h00000000;
            uni_reg    <= 1'b0;
            method_reg <= 2'h0;
            ip_reg     <= 32'h00000000;
            ctrl_reg   <= 4'h0;
            period_reg <= `RBG_RST_PERIOD;
            tmo_reg    <= `RBG_RST_TIMEOUT;
            win_reg    <= `RBG_RST_WINDOW;
            pset_reg   <= 7'h00;
        end else begin
            wait_reg   <= wait_next;
            rdata_reg  <= rdata_next;
            uni_reg    <= uni_next;
            method_reg <= method_next;
            ip_reg     <= ip_next;
            ctrl_reg   <= ctrl_next;
            period_reg <= period_next;
            tmo_reg    <= tmo_next;
            win_reg    <= win_next;
            pset_reg   <= pset_next;
        end
    end

    // Beacon engine: takeover sequence, period timer, egress
    always_comb begin
        assist      = ctrl_reg[`RBG_BIT_ASSIST];
        tx_on       = ctrl_reg[`RBG_BIT_TX_ON];
        backup      = ctrl_reg[`RBG_BIT_BACKUP];
        active      = assist && (tx_on || st_reg == rbg_pkg::ST_AUTO);
        loss        = {loss_port2, loss_port1};
        p1          = rbg_first(pset_reg);
        p2          = rbg_first(pset_reg & ~p1);
        st_next     = st_reg;
        seen_next   = seen_reg;
        wcnt_next   = wcnt_reg;
        case (st_reg)
            rbg_pkg::ST_IDLE: begin
                if (backup && !bk_prev_reg) st_next = rbg_pkg::ST_ARMED;
            end
            rbg_pkg::ST_ARMED: begin
                seen_next = loss;
                wcnt_next = 22'h000000;
                if (loss == 2'h3) st_next = rbg_pkg::ST_HOLD;
                else if (loss != 2'h0) st_next = rbg_pkg::ST_WAIT2;
            end
            rbg_pkg::ST_WAIT2: begin
                if ((loss & ~seen_reg) != 2'h0) begin
                    st_next   = rbg_pkg::ST_HOLD;
                    wcnt_next = 22'h000000;
                end else if (us_tick && win_reg != 22'h000000) begin
                    wcnt_next = wcnt_reg + 22'h000001;
                    if (wcnt_next >= win_reg) st_next = rbg_pkg::ST_ARMED;
                end
            end
            rbg_pkg::ST_HOLD: begin
                if (us_tick) begin
                    wcnt_next = wcnt_reg + 22'h000001;
                    if (wcnt_next >= tmo_reg) st_next = rbg_pkg::ST_AUTO;
                end
            end
            default: begin
            end
        endcase
        // Without assist or backup bit the takeover machine stays in ST_IDLE
        if (!assist || !backup) st_next = rbg_pkg::ST_IDLE;
        // A transmit enable that drops disarms until the backup bit is cleared and set again
        if (tx_prev_reg && !tx_on) st_next = rbg_pkg::ST_IDLE;
        // Interval in whole microseconds; zero means every tick
        fire      = 1'b0;
        icnt_next = 32'h00000000;
        if (active) begin
            icnt_next = icnt_reg;
            if (us_tick) begin
                icnt_next = icnt_reg + 32'h00000001;
                if (icnt_next >= period_reg) begin
                    fire      = 1'b1;
                    icnt_next = 32'h00000000;
                end
            end
        end
        send_next   = 1'b0;
        pend_next   = 1'b0;
        uniout_next = uni_reg;
        ports_next  = ports_reg;
        if (fire) begin
            send_next = 1'b1;
            if (!uni_reg) begin
                ports_next = p1 | p2;
            end else begin
                ports_next = p1;
                pend_next  = (method_reg == `RBG_METHOD_PAIR);
            end
        end else if (pend_reg && active) begin
            send_next  = 1'b1;
            ports_next = p2;
        end
        // Clear wins while held; frames of a pair share one ID
        if (ctrl_reg[`RBG_BIT_SEQ_CLR]) seq_next = 16'h0000;
        else if (fire) seq_next = seq_reg + 16'h0001;
        else seq_next = seq_reg;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_reg      <= rbg_pkg::ST_IDLE;
            bk_prev_reg <= 1'b0;
            tx_prev_reg <= 1'b0;
            seen_reg    <= 2'h0;
            wcnt_reg    <= 22'h000000;
            icnt_reg    <= 32'h00000000;
            seq_reg     <= 16'h0000;
            pend_reg    <= 1'b0;
            send_reg    <= 1'b0;
            uniout_reg  <= 1'b0;
            ports_reg   <= 7'h00;
            act_reg     <= 1'b0;
        end else begin
            st_reg      <= st_next;
            bk_prev_reg <= backup;
            tx_prev_reg <= tx_on;
            seen_reg    <= seen_next;
            wcnt_reg    <= wcnt_next;
            icnt_reg    <= icnt_next;
            seq_reg     <= seq_next;
            pend_reg    <= pend_next;
            send_reg    <= send_next;
            uniout_reg  <= uniout_next;
            ports_reg   <= ports_next;
            act_reg     <= active;
        end
    end

    assign avs_readdata          = rdata_reg;
    assign avs_waitrequest       = wait_reg;
    assign beacon_send           = send_reg;
    assign beacon_ports          = ports_reg;
    assign beacon_unicast        = uniout_reg;
    assign beacon_seq_id         = seq_reg;
    assign beacon_ip_field       = ip_reg;
    assign beacon_interval_field = period_reg;
    assign beacon_timeout_field  = tmo_reg;
    assign ring_hw_assist_on     = ctrl_reg[`RBG_BIT_ASSIST];
    assign supervisor_active     = act_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_send_needs_on: assert property (send_reg |-> $past(active))
        else $error("Beacon sent while not active");
    a_no_assist_quiet: assert property (!$past(assist) |-> !send_reg)
        else $error("Beacon sent with assist off");
    a_seq_clear: assert property ($past(ctrl_reg[3]) |-> seq_reg == 16'h0000)
        else $error("Sequence ID not cleared");
    a_seq_step: assert property (fire && !ctrl_reg[3] |=> seq_reg == $past(seq_reg) + 16'h0001)
        else $error("Sequence ID did not step");
    a_mcast_ports: assert property (fire && !uni_reg |=> ports_reg == $past(p1 | p2))
        else $error("Multicast ports wrong");
    a_pair_second: assert property (fire && uni_reg && method_reg == 2'h1 && assist
        ##1 active |=> send_reg && ports_reg == $past(p2, 2))
        else $error("Second unicast frame missing");
    a_hold_done: assert property (st_reg == rbg_pkg::ST_AUTO && $past(st_reg) == rbg_pkg::ST_HOLD
        |-> $past(wcnt_reg) + 22'h000001 >= $past(tmo_reg))
        else $error("Takeover before hold time");
    a_window_drop: assert property (st_reg == rbg_pkg::ST_ARMED && $past(st_reg) == rbg_pkg::ST_WAIT2
        |-> $past(win_reg) != 22'h000000)
        else $error("Zero window timed out");
    a_tx_disarm: assert property ($fell(tx_on) |=> st_reg == rbg_pkg::ST_IDLE)
        else $error("Backup not disarmed");
    a_period_met: assert property (fire |-> icnt_reg + 32'h00000001 >= period_reg)
        else $error("Beacon before period");

    c_takeover: cover property ($past(st_reg) == rbg_pkg::ST_HOLD && st_reg == rbg_pkg::ST_AUTO);
    c_pair: cover property (send_reg && uniout_reg ##1 send_reg);
    c_seq_clr: cover property ($fell(ctrl_reg[3]) && seq_reg == 16'h0000);
    c_window: cover property ($past(st_reg) == rbg_pkg::ST_WAIT2 && st_reg == rbg_pkg::ST_ARMED);

endmodule : rbg_top

// [verif/rbg_peer_model.sv]
`timescale 1ns/100ps
module rbg_peer_model (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        beacon_send,
    input  wire logic [6:0]  beacon_ports,
    input  wire logic [1:0]  loss_req,
    output logic             loss_port1,
    output logic             loss_port2,
    output logic      [15:0] rx_count
);
    logic [15:0] rx_next;
    logic [1:0]  loss_next;

    // Peers count frames that reach a port; loss is a one-cycle timeout report
    always_comb begin
        loss_next = loss_req;
        rx_next   = rx_count;
        if (beacon_send && (beacon_ports != 7'h00)) begin
            rx_next = rx_count + 16'h0001;
        end
    end

    // Registered so loss pulses change just after an edge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            loss_port1 <= 1'b0;
            loss_port2 <= 1'b0;
            rx_count   <= 16'h0000;
        end else begin
            loss_port1 <= loss_next[0];
            loss_port2 <= loss_next[1];
            rx_count   <= rx_next;
        end
    end
endmodule : rbg_peer_model

// [verif/tb.sv]
`timescale 1ns/100ps
`include "rbg_consts.svh"
module tb;
    logic        clk_sys;
    logic        reset;
    logic [11:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        loss_port1;
    logic        loss_port2;
    logic [1:0]  loss_req;
    logic        beacon_send;
    logic [6:0]  beacon_ports;
    logic        beacon_unicast;
    logic [15:0] beacon_seq_id;
    logic [31:0] beacon_ip_field;
    logic [31:0] beacon_interval_field;
    logic [21:0] beacon_timeout_field;
    logic        ring_hw_assist_on;
    logic        supervisor_active;
    logic [15:0] rx_count;
    logic [15:0] rx_a;
    logic [15:0] seq_a;
    logic [31:0] rdata;
    int          err_count;
    int          n_checks;
    int          cyc;

    rbg_top i_dut (.clk_sys, .reset, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .loss_port1, .loss_port2, .beacon_send, .beacon_ports, .beacon_unicast,
        .beacon_seq_id, .beacon_ip_field, .beacon_interval_field,
        .beacon_timeout_field, .ring_hw_assist_on, .supervisor_active);

    rbg_peer_model i_peer (.clk_sys, .reset, .beacon_send, .beacon_ports,
        .loss_req, .loss_port1, .loss_port2, .rx_count);

    // Free-running 50 MHz core clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic end_sim;
        $display("Checks %0d, errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One Avalon access; a trailing idle cycle keeps drivers single-assigned
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            err_count++;
            end_sim();
        end
        @(posedge clk_sys);
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk(rdata, e);
    endtask : rchk

    // Counts edges up to the next frame; a missing required frame ends the run
    task automatic wait_send(input int lim, input logic must);
        cyc = 0;
        do begin
            @(posedge clk_sys);
            cyc++;
        end while (beacon_send !== 1'b1 && cyc < lim);
        if (must && beacon_send !== 1'b1) begin
            err_count++;
            end_sim();
        end
    endtask : wait_send

    // Peer timeout request; the idle edge after it avoids double assignment
    task automatic loss(input logic [1:0] m);
        loss_req <= m;
        @(posedge clk_sys);
        loss_req <= 2'h0;
        @(posedge clk_sys);
    endtask : loss

    // Main sequence
    initial begin
        err_count = 0;
        n_checks = 0;
        reset = 1'b1;
        avs_address = 12'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hF;
        loss_req = 2'h0;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        chk(beacon_interval_field, 32'h00000190);
        chk({10'h000, beacon_timeout_field}, 32'h000007A8);
        rchk(`RBG_OFS_SEND_SEL, 32'h00000000);
        rchk(`RBG_OFS_SRC_IP, 32'h00000000);
        rchk(`RBG_OFS_CTRL, 32'h00000000);
        rchk(`RBG_OFS_PERIOD, 32'h00000190);
        rchk(`RBG_OFS_TIMEOUT, 32'h000007A8);
        rchk(`RBG_OFS_WINDOW, 32'h00001770);
        rchk(`RBG_OFS_PORT_SET, 32'h00000000);
        wr(12'h600, 32'hFFFFFFFF);
        rchk(12'h600, 32'h00000000);
        wr(`RBG_OFS_SEND_SEL, 32'hFFFFFFFF);
        rchk(`RBG_OFS_SEND_SEL, 32'h80000003);
        wr(`RBG_OFS_CTRL, 32'hFFFFFFF0);
        rchk(`RBG_OFS_CTRL, 32'h00000000);
        wr(`RBG_OFS_TIMEOUT, 32'hFFC00004);
        rchk(`RBG_OFS_TIMEOUT, 32'h00000004);
        chk({10'h000, beacon_timeout_field}, 32'h00000004);
        wr(`RBG_OFS_PORT_SET, 32'hFFFFFF06);
        rchk(`RBG_OFS_PORT_SET, 32'h00000006);
        wr(`RBG_OFS_SRC_IP, 32'hC0A80A05);
        rchk(`RBG_OFS_SRC_IP, 32'hC0A80A05);
        // Low two byte lanes only; upper bytes must keep their value
        avs_byteenable <= 4'h3;
        wr(`RBG_OFS_SRC_IP, 32'h11112222);
        avs_byteenable <= 4'hF;
        rchk(`RBG_OFS_SRC_IP, 32'hC0A82222);
        wr(`RBG_OFS_PERIOD, 32'h00000002);
        chk(beacon_interval_field, 32'h00000002);
        wr(`RBG_OFS_SEND_SEL, 32'h00000000);
        // Multicast beaconing at a 2 us period
        wr(`RBG_OFS_CTRL, 32'h00000003);
        chk(ring_hw_assist_on, 32'h1);
        wait_send(300, 1'b1);
        chk(beacon_ports, 32'h06);
        chk(beacon_unicast, 32'h0);
        chk(beacon_seq_id, 32'h1);
        chk(beacon_ip_field, 32'hC0A82222);
        wait_send(300, 1'b1);
        chk(cyc, 32'd100);
        chk(beacon_seq_id, 32'h2);
        chk(supervisor_active, 32'h1);
        // Unicast pair on port 1 then port 2 under one sequence ID
        wr(`RBG_OFS_SEND_SEL, 32'h80000001);
        rx_a = rx_count;
        wait_send(300, 1'b1);
        seq_a = beacon_seq_id;
        chk(beacon_ports, 32'h02);
        chk(beacon_unicast, 32'h1);
        chk(seq_a, 32'h3);
        @(posedge clk_sys);
        chk(beacon_send, 32'h1);
        chk(beacon_ports, 32'h04);
        chk(beacon_seq_id, seq_a);
        @(posedge clk_sys);
        chk(rx_count - rx_a, 32'h2);
        // Transmit off, sequence clear, then assist off
        wr(`RBG_OFS_CTRL, 32'h00000001);
        wait_send(300, 1'b0);
        chk(beacon_send, 32'h0);
        wr(`RBG_OFS_CTRL, 32'h00000009);
        wr(`RBG_OFS_CTRL, 32'h00000001);
        wr(`RBG_OFS_SEND_SEL, 32'h00000000);
        wr(`RBG_OFS_CTRL, 32'h00000002);
        chk(ring_hw_assist_on, 32'h0);
        wait_send(300, 1'b0);
        chk(beacon_send, 32'h0);
        wr(`RBG_OFS_CTRL, 32'h00000003);
        wait_send(300, 1'b1);
        chk(beacon_seq_id, 32'h1);
        // Backup takeover: unarmed, window expiry, then a real takeover
        wr(`RBG_OFS_CTRL, 32'h00000001);
        loss(2'h1);
        loss(2'h2);
        wait_send(400, 1'b0);
        chk(beacon_send, 32'h0);
        wr(`RBG_OFS_WINDOW, 32'h00000001);
        wr(`RBG_OFS_CTRL, 32'h00000005);
        loss(2'h1);
        repeat (150) @(posedge clk_sys);
        loss(2'h2);
        wait_send(400, 1'b0);
        chk(beacon_send, 32'h0);
        // Window of 3 us so the two loss pulses cannot straddle an expiry
        wr(`RBG_OFS_WINDOW, 32'h00000003);
        loss(2'h1);
        loss(2'h2);
        wait_send(500, 1'b1);
        chk(cyc > 200, 32'h1);
        chk(supervisor_active, 32'h1);
        rchk(`RBG_OFS_STATUS, 32'h00020014);
        // Transmit toggle disarms; re-arm with a zero window
        wr(`RBG_OFS_CTRL, 32'h00000007);
        wr(`RBG_OFS_CTRL, 32'h00000005);
        // Active flag trails the disarm by two edges
        repeat (2) @(posedge clk_sys);
        chk(supervisor_active, 32'h0);
        loss(2'h1);
        loss(2'h2);
        wait_send(500, 1'b0);
        chk(beacon_send, 32'h0);
        wr(`RBG_OFS_WINDOW, 32'h00000000);
        wr(`RBG_OFS_CTRL, 32'h00000001);
        wr(`RBG_OFS_CTRL, 32'h00000005);
        loss(2'h1);
        repeat (400) @(posedge clk_sys);
        loss(2'h2);
        wait_send(500, 1'b1);
        chk(supervisor_active, 32'h1);
        end_sim();
    end
endmodule : tb
